// >>> design/lsmb_bank.sv
// limit status, upper pin mask and internal temperature register bank
module lsmb_bank (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // classic wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [lsmb_pkg::WB_ADR_W-1:0] adr_i,
  input  wire logic [3:0]                    sel_i,
  input  wire logic [lsmb_pkg::WB_DAT_W-1:0] dat_i,
  output logic      [lsmb_pkg::WB_DAT_W-1:0] dat_o,
  output logic                               ack_o,
  // converter results, same clock
  input  wire logic                          conv_valid_i,
  input  wire logic [lsmb_pkg::CHAN_W-1:0]   conv_chan_i,
  input  wire logic [lsmb_pkg::REG_W-1:0]    conv_value_i,
  input  wire logic [lsmb_pkg::REG_W-1:0]    limit_high_i,
  input  wire logic [lsmb_pkg::REG_W-1:0]    limit_low_i,
  input  wire logic [lsmb_pkg::REG_W-1:0]    ot_limit_i,
  input  wire logic                          diode_two_volt_i,
  // upper pin bank levels, asynchronous
  input  wire logic [7:0]                    pin_bank_upper_i,
  output logic [1:0]                         overtemp_mode_o,
  output logic                               irq_o
);
  import lsmb_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [REG_W-1:0] pin_mask;
  logic [REG_W-1:0] trim;
  logic [REG_W-1:0] reading;
  logic [REG_W-1:0] stat_first;
  logic [REG_W-1:0] stat_ain;
  logic [REG_W-1:0] pin_pend;
  logic [REG_W-1:0] lim_pend;
  logic [REG_W-1:0] lim_mask;
  logic [7:0]       pin_s1;
  logic [7:0]       pin_s2;
  logic [7:0]       pin_s3;
  logic [7:0]       pin_evt;
  logic [IDX_W-1:0] idx;
  logic             bus_req;
  logic             wr_lo;
  logic             oow;
  logic             is_signed;
  logic             ot_mode_one;
  logic             ot_mode_two;
  logic             eng_one;
  logic             rel_one;
  logic             eng_two;
  logic             rel_two;
  logic             smp_one;
  logic             smp_two;
  logic             ot_evt;
  logic [REG_W-1:0] corrected;
  logic [REG_W-1:0] next_stat_first;
  logic [REG_W-1:0] next_stat_ain;
  logic [REG_W-1:0] next_dat;

  // saturating add of a signed trim to a signed result
  function automatic logic [7:0] trim_add(input logic [7:0] v,
                                          input logic [7:0] t);
    logic signed [8:0] s;
    s = $signed({v[7], v}) + $signed({t[7], t});
    if (s > 9'sd127)
      trim_add = 8'h7f;
    else if (s < -9'sd128)
      trim_add = 8'h80;
    else
      trim_add = s[7:0];
  endfunction

  // one-hot strobe of a channel inside a register
  function automatic logic [7:0] chan_bit(input logic [2:0] b);
    chan_bit = 8'h01 << b;
  endfunction

  // ****************************************
  // wishbone slave
  // ****************************************
  assign idx     = adr_i[WB_ADR_W-1:2];
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_lo   = cyc_i && stb_i && ack_o && we_i && sel_i[0]; // ack edge

  // one wait state, ack drops the cycle after it was given
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= bus_req;
  end

  // read mux, unmapped and reserved read as zero
  always_comb begin
    next_dat = RST_REG;
    unique case (idx)
      IDX_PIN_MASK:   next_dat = pin_mask;
      IDX_TRIM:       next_dat = trim;
      IDX_READING:    next_dat = reading;
      IDX_STAT_FIRST: next_dat = stat_first;
      IDX_STAT_AIN:   next_dat = stat_ain;
      IDX_PIN_PEND:   next_dat = pin_pend;
      IDX_LIM_PEND:   next_dat = lim_pend;
      IDX_LIM_MASK:   next_dat = lim_mask;
      default:        next_dat = RST_REG;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i)
      dat_o <= '0;
    else if (bus_req && !we_i)
      dat_o <= {{(WB_DAT_W-REG_W){1'b0}}, next_dat};
  end

  // ****************************************
  // writable control registers
  // ****************************************
  // upper pin mask, zero at reset leaves every pin unmasked
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin_mask <= RST_REG;
    else if (wr_lo && idx == IDX_PIN_MASK)
      pin_mask <= dat_i[REG_W-1:0];
  end

  // internal temperature trim, signed
  always_ff @(posedge clk_i) begin
    if (rst_i)
      trim <= RST_REG;
    else if (wr_lo && idx == IDX_TRIM)
      trim <= dat_i[REG_W-1:0];
  end

  // mask of the limit event pending bits
  always_ff @(posedge clk_i) begin
    if (rst_i)
      lim_mask <= RST_REG;
    else if (wr_lo && idx == IDX_LIM_MASK)
      lim_mask <= dat_i[REG_W-1:0];
  end

  // ****************************************
  // conversion results
  // ****************************************
  // remote channel two is unsigned when it measures a voltage
  assign is_signed = (conv_chan_i == CH_DIODE_ONE) ||
                     (conv_chan_i == CH_INT_TEMP) ||
                     (conv_chan_i == CH_DIODE_TWO && !diode_two_volt_i);

  // the internal result is corrected before storage and compare
  assign corrected = trim_add(conv_value_i, trim);

  lsmb_window_cmp u_cmp (
    .value_i  (conv_chan_i == CH_INT_TEMP ? corrected : conv_value_i),
    .high_i   (limit_high_i),
    .low_i    (limit_low_i),
    .signed_i (is_signed),
    .out_o    (oow)
  );

  assign smp_one = conv_valid_i && conv_chan_i == CH_DIODE_ONE;
  assign smp_two = conv_valid_i && conv_chan_i == CH_DIODE_TWO;

  lsmb_overtemp u_ot_one (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sample_i  (smp_one),
    .enable_i  (1'b1),
    .value_i   (conv_value_i),
    .limit_i   (ot_limit_i),
    .mode_o    (ot_mode_one),
    .engage_o  (eng_one),
    .release_o (rel_one)
  );

  // no overtemp tracking while channel two reads a voltage
  lsmb_overtemp u_ot_two (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .sample_i  (smp_two),
    .enable_i  (!diode_two_volt_i),
    .value_i   (conv_value_i),
    .limit_i   (ot_limit_i),
    .mode_o    (ot_mode_two),
    .engage_o  (eng_two),
    .release_o (rel_two)
  );

  assign overtemp_mode_o = {ot_mode_two, ot_mode_one};
  assign ot_evt = eng_one || rel_one || eng_two || rel_two;

  // each conversion rewrites only its own channel's bit
  always_comb begin
    next_stat_first = stat_first;
    next_stat_ain   = stat_ain;
    if (conv_valid_i && conv_chan_i <= CH_RAIL_LAST) begin
      if (oow || ot_evt)
        next_stat_first = stat_first | chan_bit(conv_chan_i[2:0]);
      else
        next_stat_first = stat_first & ~chan_bit(conv_chan_i[2:0]);
    end
    if (conv_valid_i && conv_chan_i >= CH_AIN_FIRST &&
        conv_chan_i <= CH_AIN_LAST) begin
      if (oow)
        next_stat_ain = stat_ain | chan_bit(conv_chan_i[2:0]);
      else
        next_stat_ain = stat_ain & ~chan_bit(conv_chan_i[2:0]);
    end
  end

  // status is hardware-owned, bus writes never reach it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_first <= RST_REG;
      stat_ain   <= RST_REG;
    end else begin
      stat_first <= next_stat_first;
      stat_ain   <= next_stat_ain;
    end
  end

  // latest corrected internal temperature, read-only
  always_ff @(posedge clk_i) begin
    if (rst_i)
      reading <= RST_REG;
    else if (conv_valid_i && conv_chan_i == CH_INT_TEMP)
      reading <= corrected;
  end

  // ****************************************
  // upper pin events and interrupts
  // ****************************************
  // two-flop synchroniser, the third flop only feeds the edge detect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else begin
      pin_s1 <= pin_bank_upper_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign pin_evt = pin_s2 & ~pin_s3;

  // sticky, cleared by writing one; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin_pend <= RST_REG;
    else if (wr_lo && idx == IDX_PIN_PEND)
      pin_pend <= (pin_pend & ~dat_i[REG_W-1:0]) | pin_evt;
    else
      pin_pend <= pin_pend | pin_evt;
  end

  // limit events: new flag in either status, or overtemp change
  always_ff @(posedge clk_i) begin
    if (rst_i)
      lim_pend <= RST_REG;
    else if (wr_lo && idx == IDX_LIM_PEND)
      lim_pend <= (lim_pend & ~dat_i[REG_W-1:0]) |
                  {5'h00, ot_evt, |(next_stat_ain & ~stat_ain),
                   |(next_stat_first & ~stat_first)};
    else
      lim_pend <= lim_pend |
                  {5'h00, ot_evt, |(next_stat_ain & ~stat_ain),
                   |(next_stat_first & ~stat_first)};
  end

  // level output, a masked pin never raises it
  assign irq_o = |(pin_pend & ~pin_mask) || |(lim_pend & ~lim_mask);

  // ****************************************
  // checks
  // ****************************************
  property p_pin_mask_gate;
    @(posedge clk_i) disable iff (rst_i)
    (lim_pend & ~lim_mask) == 8'h00 && (pin_pend & ~pin_mask) == 8'h00
      |-> !irq_o;
  endproperty
  a_pin_mask_gate: assert property (p_pin_mask_gate)
    else $error("interrupt raised by a masked source");

  property p_mask_reset;
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> pin_mask == 8'h00 && stat_first == 8'h00;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask or status not zero after reset");

  property p_int_reading;
    @(posedge clk_i) disable iff (rst_i)
    conv_valid_i && conv_chan_i == CH_INT_TEMP
      |=> reading == trim_add($past(conv_value_i), $past(trim));
  endproperty
  a_int_reading: assert property (p_int_reading)
    else $error("internal reading not trimmed result");

  property p_diode_one;
    @(posedge clk_i) disable iff (rst_i)
    smp_one && (oow || eng_one || rel_one) |=> stat_first[0];
  endproperty
  a_diode_one: assert property (p_diode_one)
    else $error("remote one status bit not set");

  property p_diode_two;
    @(posedge clk_i) disable iff (rst_i)
    smp_two |=> stat_first[1] == $past(oow || eng_two || rel_two);
  endproperty
  a_diode_two: assert property (p_diode_two)
    else $error("remote two status bit wrong");

  property p_rails;
    @(posedge clk_i) disable iff (rst_i)
    conv_valid_i && conv_chan_i > CH_DIODE_TWO &&
      conv_chan_i <= CH_RAIL_LAST
      |=> stat_first[$past(conv_chan_i[2:0])] == $past(oow);
  endproperty
  a_rails: assert property (p_rails)
    else $error("rail status bit wrong");

  property p_ain;
    @(posedge clk_i) disable iff (rst_i)
    conv_valid_i && conv_chan_i >= CH_AIN_FIRST &&
      conv_chan_i <= CH_AIN_LAST
      |=> stat_ain[$past(conv_chan_i[2:0])] == $past(oow);
  endproperty
  a_ain: assert property (p_ain)
    else $error("analog input status bit wrong");

  property p_stat_ro;
    @(posedge clk_i) disable iff (rst_i)
    !conv_valid_i |=> $stable(stat_first) && $stable(stat_ain);
  endproperty
  a_stat_ro: assert property (p_stat_ro)
    else $error("status changed without a conversion");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single cycle after request");

endmodule

// >>> design/lsmb_overtemp.sv
// overtemp mode tracker of one remote channel with exit hysteresis
module lsmb_overtemp (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       sample_i,
  input  wire logic                       enable_i,
  input  wire logic [lsmb_pkg::REG_W-1:0] value_i,
  input  wire logic [lsmb_pkg::REG_W-1:0] limit_i,
  output logic                            mode_o,
  output logic                            engage_o,
  output logic                            release_o
);
  import lsmb_pkg::*;

  logic signed [8:0] val_s;
  logic signed [8:0] lim_s;

  // temperatures are two's complement degrees
  assign val_s = $signed({value_i[7], value_i});
  assign lim_s = $signed({limit_i[7], limit_i});

  // one pulse on entry, one on exit 5 below the limit
  assign engage_o  = sample_i && enable_i && !mode_o && (val_s > lim_s);
  assign release_o = sample_i && enable_i && mode_o &&
                     (val_s <= lim_s - $signed(OT_HYST_C));

  // mode drops at once if the channel leaves temperature use
  always_ff @(posedge clk_i) begin
    if (rst_i)
      mode_o <= 1'b0;
    else if (!enable_i || release_o)
      mode_o <= 1'b0;
    else if (engage_o)
      mode_o <= 1'b1;
  end

  property p_ot_engage;
    @(posedge clk_i) disable iff (rst_i)
    engage_o |=> mode_o;
  endproperty
  a_ot_engage: assert property (p_ot_engage)
    else $error("overtemp mode not entered after engage");

  property p_ot_release;
    @(posedge clk_i) disable iff (rst_i)
    release_o |=> !mode_o ##0 !release_o;
  endproperty
  a_ot_release: assert property (p_ot_release)
    else $error("overtemp mode still set after release");

endmodule

// >>> design/lsmb_pkg.sv
// constants and register map for the limit status and mask bank
//
// Contract
// - a set bit in pin_bank_upper_mask blocks that upper pin's interrupt
// - pin_bank_upper_mask is all zero after reset
// - signed trim is added to each internal temperature result
// - internal_temp_reading is read-only, latest corrected internal result
// - status first bit0 flags remote_diode_one out of window last conversion
// - bit0 also set once when overtemp_mode engages on remote_diode_one
// - bit0 set once more when remote_diode_one falls 5 C below limit
// - bit1 flags remote_diode_two, or analog_in_nine in voltage mode
// - bit1 set once on remote_diode_two overtemp entry and once on exit; an exit forced by voltage mode leaves bit1 unset
// - bits 2..7 flag standby, main 3v3, 5v, cpu core, 12v, -12v rails
// - second status bits 0..7 flag analog inputs 0..7 out of window
// - first status register is read-only and zero after reset
package lsmb_pkg;

  // ****************************************
  // bus shape
  // ****************************************
  localparam int WB_ADR_W = 8;
  localparam int WB_DAT_W = 32;
  localparam int REG_W    = 8;
  localparam int IDX_W    = 6;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_PIN_MASK   = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_TRIM       = 6'h1e;
  localparam logic [IDX_W-1:0] IDX_READING    = 6'h1f;
  localparam logic [IDX_W-1:0] IDX_STAT_FIRST = 6'h20;
  localparam logic [IDX_W-1:0] IDX_STAT_AIN   = 6'h21;
  localparam logic [IDX_W-1:0] IDX_PIN_PEND   = 6'h24;
  localparam logic [IDX_W-1:0] IDX_LIM_PEND   = 6'h25;
  localparam logic [IDX_W-1:0] IDX_LIM_MASK   = 6'h26;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  // ****************************************
  // converter channel codes
  // ****************************************
  localparam int CHAN_W = 5;
  localparam logic [CHAN_W-1:0] CH_DIODE_ONE = 5'h00;
  localparam logic [CHAN_W-1:0] CH_DIODE_TWO = 5'h01;
  localparam logic [CHAN_W-1:0] CH_RAIL_LAST = 5'h07;
  localparam logic [CHAN_W-1:0] CH_AIN_FIRST = 5'h08;
  localparam logic [CHAN_W-1:0] CH_AIN_LAST  = 5'h0f;
  localparam logic [CHAN_W-1:0] CH_INT_TEMP  = 5'h10;

  // ****************************************
  // limit event pending bits
  // ****************************************
  localparam int LP_FIRST = 0;
  localparam int LP_AIN   = 1;
  localparam int LP_OT    = 2;

  // overtemp exit hysteresis in degrees
  localparam logic [8:0] OT_HYST_C = 9'h005;

endpackage

// >>> design/lsmb_window_cmp.sv
// out-of-window compare of one conversion result against its limits
module lsmb_window_cmp (
  input  wire logic [lsmb_pkg::REG_W-1:0] value_i,
  input  wire logic [lsmb_pkg::REG_W-1:0] high_i,
  input  wire logic [lsmb_pkg::REG_W-1:0] low_i,
  input  wire logic                       signed_i,
  output logic                            out_o
);
  import lsmb_pkg::*;

  // sign or zero extend so temps and volts share one comparator
  function automatic logic signed [8:0] ext9(input logic [7:0] v,
                                             input logic s);
    ext9 = $signed({s & v[7], v});
  endfunction

  // above high or below low
  always_comb begin
    out_o = (ext9(value_i, signed_i) > ext9(high_i, signed_i)) ||
            (ext9(value_i, signed_i) < ext9(low_i, signed_i));
  end

endmodule

// >>> tb/lsmb_host_model.sv
// host side model: classic wishbone single-cycle bus master
module lsmb_host_model (
  input  wire logic                          clk_i,
  input  wire logic [lsmb_pkg::WB_DAT_W-1:0] dat_i,
  input  wire logic                          ack_i,
  output logic                               cyc_o,
  output logic                               stb_o,
  output logic                               we_o,
  output logic [lsmb_pkg::WB_ADR_W-1:0]      adr_o,
  output logic [3:0]                         sel_o,
  output logic [lsmb_pkg::WB_DAT_W-1:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import lsmb_pkg::*;

  // idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = '0;
    sel_o = 4'h0;
    dat_o = '0;
  end

  // ****************
  // one transfer
  // ****************
  // request held until ack is seen high, released at that edge;
  // released address and data go inverted so a stale value is never trusted
  task automatic xfer(input logic w, input logic [IDX_W-1:0] idx,
                      input logic [REG_W-1:0] wd,
                      output logic [WB_DAT_W-1:0] rd, output bit ok);
    int n;
    n  = 0;
    ok = 1'b0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'hf;
    dat_o <= {24'h000000, wd};
    while (!ok && n < 64) begin
      @(posedge clk_i);
      ok = (ack_i === 1'b1);
      n++;
    end
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    sel_o <= 4'h0;
    adr_o <= ~adr_o;
    dat_o <= ~dat_o;
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the limit status and mask bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lsmb_pkg::*;

  // ****************
  // signals
  // ****************
  logic                clk_i;
  logic                rst_i;
  logic                cyc;
  logic                stb;
  logic                we;
  logic [WB_ADR_W-1:0] adr;
  logic [3:0]          sel;
  logic [WB_DAT_W-1:0] wdat;
  logic [WB_DAT_W-1:0] rdat;
  logic                ack;
  logic                conv_valid;
  logic [CHAN_W-1:0]   conv_chan;
  logic [REG_W-1:0]    conv_value;
  logic [REG_W-1:0]    lim_hi;
  logic [REG_W-1:0]    lim_lo;
  logic [REG_W-1:0]    ot_lim;
  logic                volt;
  logic [7:0]          pins;
  logic [1:0]          ot_mode;
  logic                irq;
  int                  err_total;
  int                  cmp_count;

  lsmb_bank lsmb_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .conv_valid_i(conv_valid),
    .conv_chan_i(conv_chan), .conv_value_i(conv_value),
    .limit_high_i(lim_hi), .limit_low_i(lim_lo), .ot_limit_i(ot_lim),
    .diode_two_volt_i(volt), .pin_bank_upper_i(pins),
    .overtemp_mode_o(ot_mode), .irq_o(irq));

  lsmb_host_model lsmb_host_model_inst (.clk_i(clk_i), .dat_i(rdat),
    .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
    .sel_o(sel), .dat_o(wdat));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************
  // helpers
  // ****************
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk_reg(string what, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask

  task automatic chk_bit(string what, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %b seen %b", what, e, g);
      err_total++;
    end
  endtask

  // a missing ack ends the run, nothing after it can be trusted
  task automatic bus(input logic w, input logic [IDX_W-1:0] idx,
                     input logic [7:0] d, output logic [31:0] q);
    bit ok;
    lsmb_host_model_inst.xfer(w, idx, d, q, ok);
    if (!ok) begin
      $display("MISMATCH ack expected 1 seen 0");
      err_total++;
      final_report();
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [IDX_W-1:0] idx,
                        input logic [7:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk_reg(what, {24'h000000, e}, q);
  endtask

  // one conversion pulse; value lines go stale-inverted afterwards
  task automatic conv(input logic [4:0] ch, input logic [7:0] v,
                      hi, lo, ot);
    @(posedge clk_i);
    conv_valid <= 1'b1;
    conv_chan  <= ch;
    conv_value <= v;
    lim_hi     <= hi;
    lim_lo     <= lo;
    ot_lim     <= ot;
    @(posedge clk_i);
    conv_valid <= 1'b0;
    conv_value <= ~v;
  endtask

  task automatic step(input int k, input logic [7:0] v, hi,
                      input logic eb, em);
    logic [31:0] q;
    conv(5'(k), v, hi, 8'h80, 8'h50);
    bus(1'b0, IDX_STAT_FIRST, 8'h00, q);
    chk_bit("status flag", eb, q[k]);
    chk_bit("overtemp mode", em, ot_mode[k]);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd_chk(IDX_PIN_MASK, 8'h00, "mask reset");
    rd_chk(IDX_TRIM, 8'h00, "trim reset");
    rd_chk(IDX_STAT_FIRST, 8'h00, "status reset");
    rd_chk(6'h3f, 8'h00, "unmapped");
    chk_bit("irq reset", 1'b0, irq);
    chk_reg("overtemp reset", 32'h00000000, {30'h00000000, ot_mode});
    $display("test reset done");
  endtask

  task automatic t_access();
    wr(IDX_PIN_MASK, 8'ha5);
    rd_chk(IDX_PIN_MASK, 8'ha5, "mask rw");
    wr(IDX_STAT_FIRST, 8'hff);
    rd_chk(IDX_STAT_FIRST, 8'h00, "status ro");
    wr(6'h3f, 8'hff);
    rd_chk(6'h3f, 8'h00, "unmapped");
    wr(IDX_PIN_MASK, 8'h00);
    $display("test access done");
  endtask

  // trim, raw result, expected corrected result (saturating add)
  task automatic t_trim();
    logic [7:0] tr[4] = '{8'h05, 8'hfb, 8'h7f, 8'h80};
    logic [7:0] rw[4] = '{8'h14, 8'h02, 8'h7f, 8'hf0};
    logic [7:0] ex[4] = '{8'h19, 8'hfd, 8'h7f, 8'h80};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_TRIM, tr[i]);
      rd_chk(IDX_TRIM, tr[i], "trim rw");
      conv(CH_INT_TEMP, rw[i], 8'h7f, 8'h80, 8'h7f);
      rd_chk(IDX_READING, ex[i], "reading");
    end
    wr(IDX_READING, 8'h00);
    rd_chk(IDX_READING, 8'h80, "reading ro");
    $display("test trim done");
  endtask

  // rails and analog inputs set their bits one by one, then clear
  task automatic t_window();
    logic [15:0] e;
    e = 16'h0000;
    for (int c = 2; c < 16; c++) begin
      conv(5'(c), 8'h90, 8'h80, 8'h20, 8'h7f);
      e[c] = 1'b1;
      rd_chk(IDX_STAT_FIRST, e[7:0], "rails");
      rd_chk(IDX_STAT_AIN, e[15:8], "analog");
    end
    for (int c = 2; c < 16; c++) begin
      conv(5'(c), 8'h50, 8'h80, 8'h20, 8'h7f);
    end
    rd_chk(IDX_STAT_FIRST, 8'h00, "rails clear");
    rd_chk(IDX_STAT_AIN, 8'h00, "analog clear");
    $display("test window done");
  endtask

  // overtemp limit 0x50: enter above it, leave at 5 below it
  task automatic t_diode(input int k);
    step(k, 8'h40, 8'h30, 1'b1, 1'b0);
    step(k, 8'h40, 8'h7f, 1'b0, 1'b0);
    step(k, 8'h51, 8'h7f, 1'b1, 1'b1);
    step(k, 8'h51, 8'h7f, 1'b0, 1'b1);
    step(k, 8'h4c, 8'h7f, 1'b0, 1'b1);
    step(k, 8'h4b, 8'h7f, 1'b1, 1'b0);
    step(k, 8'h4b, 8'h7f, 1'b0, 1'b0);
    $display("test diode %0d done", k);
  endtask

  // 0x90 lies inside 0x10..0xa0 unsigned but outside it signed
  task automatic t_volt();
    volt <= 1'b1;
    conv(CH_DIODE_TWO, 8'h90, 8'ha0, 8'h10, 8'h7f);
    rd_chk(IDX_STAT_FIRST, 8'h00, "ninth input");
    volt <= 1'b0;
    conv(CH_DIODE_TWO, 8'h90, 8'ha0, 8'h10, 8'h7f);
    rd_chk(IDX_STAT_FIRST, 8'h02, "diode two");
    $display("test volt done");
  endtask

  task automatic t_pins();
    wr(IDX_LIM_PEND, 8'h07);
    @(negedge clk_i);
    chk_bit("irq idle", 1'b0, irq);
    @(posedge clk_i);
    pins <= 8'h08;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit("irq pin", 1'b1, irq);
    rd_chk(IDX_PIN_PEND, 8'h08, "pin pending");
    wr(IDX_PIN_PEND, 8'h08);
    @(negedge clk_i);
    chk_bit("irq cleared", 1'b0, irq);
    wr(IDX_PIN_MASK, 8'h10);
    pins <= 8'h18;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit("irq masked", 1'b0, irq);
    wr(IDX_PIN_MASK, 8'h00);
    @(negedge clk_i);
    chk_bit("irq unmasked", 1'b1, irq);
    wr(IDX_PIN_PEND, 8'h10);
    @(negedge clk_i);
    chk_bit("irq cleared", 1'b0, irq);
    // a new rail flag raises the limit pending bit, its mask hides it
    conv(5'h02, 8'h90, 8'h80, 8'h20, 8'h7f);
    @(negedge clk_i);
    chk_bit("irq limit", 1'b1, irq);
    rd_chk(IDX_LIM_PEND, 8'h01, "limit pending");
    wr(IDX_LIM_MASK, 8'h01);
    rd_chk(IDX_LIM_MASK, 8'h01, "limit mask");
    @(negedge clk_i);
    chk_bit("irq limit masked", 1'b0, irq);
    $display("test pins done");
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    err_total  = 0;
    cmp_count  = 0;
    rst_i      = 1'b1;
    conv_valid = 1'b0;
    conv_chan  = 5'h00;
    conv_value = 8'h00;
    lim_hi     = 8'h7f;
    lim_lo     = 8'h80;
    ot_lim     = 8'h7f;
    volt       = 1'b0;
    pins       = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_access();
    t_trim();
    t_window();
    t_diode(0);
    t_diode(1);
    t_volt();
    t_pins();
    final_report();
  end
endmodule
